// *** uefap_pkg.sv ***
package uefap_pkg;
  // Device register map
  localparam logic [7:0] DEV_MISC_ADDR = 8'h46;
  localparam logic [7:0] DEV_EP0_ADDR  = 8'h48;
  localparam logic [7:0] DEV_EP1_ADDR  = 8'h49;
  // Command/status field positions
  localparam int MB_REQ   = 0;
  localparam int MB_TX    = 1;
  localparam int MB_CLR   = 2;
  localparam int MB_SEL   = 3;
  localparam int MB_SETUP = 5;
  localparam int MB_RDY   = 6;
  localparam int MB_ZLEN  = 7;
  // Avalon register byte offsets
  localparam logic [5:0] AV_CTRL   = 6'h00;
  localparam logic [5:0] AV_STATUS = 6'h04;
  localparam logic [5:0] AV_PIPE   = 6'h08;
  localparam int AV_DATA_BIT       = 5;
  // Control word fields
  localparam int CB_START = 0;
  localparam int CB_OP    = 1;
  localparam int CB_SEL   = 4;
  localparam int CB_LEN   = 5;
  localparam int CB_KEEP  = 9;
  localparam int CB_ACK   = 10;
  // Operations
  localparam logic [2:0] OP_READ  = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_PRB_R = 3'h2;
  localparam logic [2:0] OP_PRB_W = 3'h3;
  localparam logic [2:0] OP_CLEAR = 3'h4;
  // Timing
  localparam int CLK_NS  = 100;
  localparam int GAP_NS  = 2000;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_W   = 5;
  localparam int MAX_PKT = 8;
endpackage

// *** uefap_ctrl.sv ***
//////////////////////////////////////////////////////////////////////////////
//
// Decided for this implementation: the Avalon-MM slave port.
module uefap_ctrl
  import uefap_pkg::*;
#(
  parameter int DEPTH = MAX_PKT
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Device register port
  output logic      [7:0]  dev_addr,
  output logic      [7:0]  dev_wdata,
  output logic             dev_we,
  output logic             dev_re,
  input  wire logic [7:0]  dev_rdata,
  // Device pipe events
  input  wire logic        usb_int,
  input  wire logic        active_pipe_number
);

  if (DEPTH < 1 || DEPTH > MAX_PKT) begin : g_chk
    $error("DEPTH must lie in 1..8");
  end

  typedef enum {S_IDLE, S_SETUP, S_REQ, S_WAIT, S_POLL, S_RDW, S_CHK, S_XFER, S_CAP,
                S_END1, S_END2} uefap_state_t;

  typedef struct packed {
    uefap_state_t         st;
    logic                 wait_n;
    logic [31:0]          rdata;
    logic [7:0]           daddr;
    logic [7:0]           dwdata;
    logic                 dwe;
    logic                 dre;
    logic [2:0]           op;
    logic                 sel;
    logic [3:0]           len;
    logic                 keep;
    logic                 tx;
    logic                 busy;
    logic                 done;
    logic                 seen;
    logic                 rdy;
    logic                 setup_f;
    logic                 zlen_f;
    logic [3:0]           cnt;
    logic [GAP_W-1:0]     gap;
    logic [7:0]           misc;
    logic                 pipe_evt;
    logic                 pipe_num;
    logic [7:0][7:0]      tx_buf;
    logic [7:0][7:0]      rx_buf;
  } uefap_regs_t;

  localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(GAP_CYC);
  localparam logic [3:0]       DEPTH4   = 4'(DEPTH);

  uefap_regs_t r_reg;
  uefap_regs_t r_next;

  // Command/status word as sent to the device; ready and zero-length are not driven
  function automatic logic [7:0] misc_word(input logic keep, input logic sel, input logic clr,
                                           input logic tx, input logic req);
    logic [7:0] w;
    w = 8'h00;
    w[MB_SETUP]   = keep;
    w[MB_SEL+1]   = 1'b0;
    w[MB_SEL]     = sel;
    w[MB_CLR]     = clr;
    w[MB_TX]      = tx;
    w[MB_REQ]     = req;
    return w;
  endfunction

  logic av_wr;
  logic av_rd;
  logic is_rd_op;
  logic is_wr_op;
  assign av_wr    = avs_write && !r_reg.wait_n;
  assign av_rd    = avs_read && !r_reg.wait_n;
  assign is_rd_op = (r_reg.op == OP_READ);
  assign is_wr_op = (r_reg.op == OP_WRITE);

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    r_next     = r_reg;
    r_next.dwe = 1'b0;
    r_next.dre = 1'b0;
    // One wait cycle per access keeps read data a clean registered value
    r_next.wait_n = !((avs_read || avs_write) && r_reg.wait_n);
    if (avs_read && r_reg.wait_n) begin
      r_next.rdata = 32'h0000_0000;
      if (avs_address[AV_DATA_BIT]) begin
        r_next.rdata[7:0] = r_reg.rx_buf[avs_address[4:2]];
      end else if (avs_address == AV_CTRL) begin
        r_next.rdata[CB_OP+:3]  = r_reg.op;
        r_next.rdata[CB_SEL]    = r_reg.sel;
        r_next.rdata[CB_LEN+:4] = r_reg.len;
        r_next.rdata[CB_KEEP]   = r_reg.keep;
      end else if (avs_address == AV_STATUS) begin
        r_next.rdata[0]     = r_reg.busy;
        r_next.rdata[1]     = r_reg.done;
        r_next.rdata[2]     = r_reg.rdy;
        r_next.rdata[3]     = r_reg.setup_f;
        r_next.rdata[4]     = r_reg.zlen_f;
        r_next.rdata[11:8]  = r_reg.cnt;
        r_next.rdata[23:16] = r_reg.misc;
      end else if (avs_address == AV_PIPE) begin
        r_next.rdata[0] = r_reg.pipe_evt;
        r_next.rdata[1] = r_reg.pipe_num;
      end
    end
    // Data window writes fill the outgoing packet; ignored while a transfer runs
    if (av_wr && avs_address[AV_DATA_BIT] && !r_reg.busy) begin
      r_next.tx_buf[avs_address[4:2]] = avs_writedata[7:0];
    end
    // Pipe completion is sticky; a new event wins over the acknowledge
    if (av_wr && avs_address == AV_CTRL && avs_writedata[CB_ACK]) begin
      r_next.pipe_evt = 1'b0;
    end
    if (usb_int) begin
      r_next.pipe_evt = 1'b1;
      r_next.pipe_num = active_pipe_number;
    end
    case (r_reg.st)
      S_IDLE: begin
        if (av_wr && avs_address == AV_CTRL && avs_writedata[CB_START]) begin
          r_next.op   = avs_writedata[CB_OP+:3];
          r_next.sel  = avs_writedata[CB_SEL];
          r_next.keep = avs_writedata[CB_KEEP];
          r_next.len  = (avs_writedata[CB_LEN+:4] > DEPTH4) ? DEPTH4 : avs_writedata[CB_LEN+:4];
          r_next.tx   = (avs_writedata[CB_OP+:3] == OP_WRITE) ||
                        (avs_writedata[CB_OP+:3] == OP_PRB_W);
          r_next.busy = 1'b1;
          r_next.done = 1'b0;
          r_next.seen = 1'b0;
          r_next.cnt  = 4'h0;
          r_next.st   = S_SETUP;
        end
      end
      S_SETUP: begin
        // Fields settle before the request rises
        r_next.dwe    = 1'b1;
        r_next.daddr  = DEV_MISC_ADDR;
        r_next.dwdata = misc_word(r_reg.keep, r_reg.sel, r_reg.op == OP_CLEAR, r_reg.tx, 1'b0);
        r_next.st     = S_REQ;
      end
      S_REQ: begin
        r_next.dwe    = 1'b1;
        r_next.daddr  = DEV_MISC_ADDR;
        r_next.dwdata = misc_word(r_reg.keep, r_reg.sel, r_reg.op == OP_CLEAR, r_reg.tx, 1'b1);
        r_next.gap    = GAP_LOAD;
        r_next.st     = (r_reg.op == OP_CLEAR) ? S_END2 : S_WAIT;
      end
      S_WAIT: begin
        if (r_reg.gap == '0) begin
          r_next.st = S_POLL;
        end else begin
          r_next.gap = r_reg.gap - GAP_W'(1);
        end
      end
      S_POLL: begin
        r_next.dre   = 1'b1;
        r_next.daddr = DEV_MISC_ADDR;
        r_next.st    = S_RDW;
      end
      S_RDW: begin
        // Device answers in the cycle after the read strobe
        r_next.st = (r_reg.daddr == DEV_MISC_ADDR) ? S_CHK : S_CAP;
      end
      S_CHK: begin
        r_next.misc    = dev_rdata;
        r_next.rdy     = dev_rdata[MB_RDY];
        r_next.setup_f = dev_rdata[MB_SETUP];
        r_next.zlen_f  = dev_rdata[MB_ZLEN];
        r_next.gap     = GAP_LOAD;
        if (r_reg.op == OP_PRB_R || r_reg.op == OP_PRB_W) begin
          r_next.st = S_END2;
        end else if (is_rd_op) begin
          if (dev_rdata[MB_RDY]) begin
            r_next.seen = 1'b1;
            r_next.st   = (r_reg.cnt == DEPTH4) ? S_END1 : S_XFER;
          end else begin
            r_next.st = r_reg.seen ? S_END1 : S_WAIT;
          end
        end else begin
          if (r_reg.cnt == r_reg.len && (dev_rdata[MB_RDY] || r_reg.seen)) begin
            r_next.st = S_END1;
          end else if (dev_rdata[MB_RDY]) begin
            r_next.seen = 1'b1;
            r_next.st   = S_XFER;
          end else begin
            r_next.st = r_reg.seen ? S_END1 : S_WAIT;
          end
        end
      end
      S_XFER: begin
        r_next.daddr = r_reg.sel ? DEV_EP1_ADDR : DEV_EP0_ADDR;
        r_next.gap   = GAP_LOAD;
        if (is_wr_op) begin
          r_next.dwe    = 1'b1;
          r_next.dwdata = r_reg.tx_buf[r_reg.cnt[2:0]];
          r_next.cnt    = r_reg.cnt + 4'h1;
          r_next.st     = S_WAIT;
        end else begin
          r_next.dre = 1'b1;
          r_next.st  = S_RDW;
        end
      end
      S_CAP: begin
        r_next.rx_buf[r_reg.cnt[2:0]] = dev_rdata;
        r_next.cnt = r_reg.cnt + 4'h1;
        r_next.st  = S_WAIT;
      end
      S_END1: begin
        // Direction flips while the request still stands to mark the end
        r_next.tx     = !r_reg.tx;
        r_next.dwe    = 1'b1;
        r_next.daddr  = DEV_MISC_ADDR;
        r_next.dwdata = misc_word(r_reg.keep, r_reg.sel, 1'b0, !r_reg.tx, 1'b1);
        r_next.st     = S_END2;
      end
      S_END2: begin
        r_next.dwe    = 1'b1;
        r_next.daddr  = DEV_MISC_ADDR;
        r_next.dwdata = misc_word(r_reg.keep, r_reg.sel, 1'b0, r_reg.tx, 1'b0);
        r_next.busy   = 1'b0;
        r_next.done   = 1'b1;
        r_next.st     = S_IDLE;
      end
      default: begin
        r_next.st   = S_IDLE;
        r_next.busy = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r_reg        <= '0;
      r_reg.st     <= S_IDLE;
      r_reg.wait_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign avs_readdata    = r_reg.rdata;
  assign avs_waitrequest = r_reg.wait_n;
  assign dev_addr        = r_reg.daddr;
  assign dev_wdata       = r_reg.dwdata;
  assign dev_we          = r_reg.dwe;
  assign dev_re          = r_reg.dre;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [7:0] last_misc_reg;
  logic [7:0] since_data_reg;
  logic       data_acc;
  assign data_acc = (dev_we || dev_re) && dev_addr != DEV_MISC_ADDR;

  // Helper history: last command word and cycles since the last data access
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      last_misc_reg  <= 8'h00;
      since_data_reg <= 8'hff;
    end else begin
      if (dev_we && dev_addr == DEV_MISC_ADDR) begin
        last_misc_reg <= dev_wdata;
      end
      if (data_acc) begin
        since_data_reg <= 8'h00;
      end else if (since_data_reg != 8'hff) begin
        since_data_reg <= since_data_reg + 8'h01;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  strobe_excl_a: assert property (!(dev_we && dev_re))
    else $error("device read and write strobes together");
  req_rise_a: assert property ((dev_we && dev_addr == DEV_MISC_ADDR && dev_wdata[MB_REQ] &&
                                !last_misc_reg[MB_REQ]) |-> dev_wdata[7:1] == last_misc_reg[7:1])
    else $error("request raised together with other field changes");
  end_toggle_a: assert property ((dev_we && dev_addr == DEV_MISC_ADDR && !dev_wdata[MB_REQ] &&
                                  last_misc_reg[MB_REQ] && $past(r_reg.st, 2) == S_END1) |->
                                 dev_wdata[MB_TX] != $past(r_reg.tx, 3))
    else $error("direction not toggled before request drop");
  sel_field_a: assert property ((dev_we && dev_addr == DEV_MISC_ADDR) |->
                                dev_wdata[MB_SEL+:2] == {1'b0, r_reg.sel})
    else $error("select field not 00 or 01");
  data_gap_a: assert property (data_acc |-> since_data_reg >= 8'(GAP_CYC))
    else $error("data accesses closer than two microseconds");
  pkt_max_a: assert property (r_reg.cnt <= DEPTH4)
    else $error("packet byte count above eight");
  dir_use_a: assert property ((data_acc && dev_we) |-> r_reg.op == OP_WRITE)
    else $error("data write outside a write operation");
  dir_read_a: assert property ((data_acc && dev_re) |-> ##2 r_reg.st == S_WAIT)
    else $error("data read not captured and spaced");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  probe_end_a: assert property ((r_reg.st == S_CHK && r_reg.op == OP_PRB_R) |=> r_reg.st == S_END2 ##1
                                (dev_we && !dev_wdata[MB_REQ]))
    else $error("probe did not withdraw request");

endmodule

// *** uefap_dev_model.sv ***
module uefap_dev_model
  import uefap_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Register port driven by the controller
  input  wire logic [7:0] dev_addr,
  input  wire logic [7:0] dev_wdata,
  input  wire logic       dev_we,
  input  wire logic       dev_re,
  output logic      [7:0] dev_rdata,
  // Pipe events toward the controller
  output logic            usb_int,
  output logic            active_pipe_number
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [2][8];
  logic [3:0]  cnt [2];
  logic [3:0]  rp [2];
  logic [4:0]  cmd_reg;
  logic        setup_reg;
  logic        zlen_reg;
  logic        host_busy;
  logic [15:0] hist;
  logic        ep;
  logic        ready;

  //////////////////////////////////////////////////////////////////////////////
  // Ready follows request, direction and fill level; the host holding the pipe wins
  assign ep = cmd_reg[MB_SEL];
  always_comb begin
    ready = 1'b0;
    if (cmd_reg[MB_REQ] && !host_busy) begin
      ready = cmd_reg[MB_TX] ? (cnt[ep] < 4'h8) : (rp[ep] < cnt[ep]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register port; read data toggles when idle so stale bytes never look valid
  always @(posedge sys_clk) begin
    dev_rdata <= ~dev_rdata;
    if (srst) begin
      dev_rdata <= 8'h5a;
      cmd_reg   <= 5'h00;
      setup_reg <= 1'b0;
      zlen_reg  <= 1'b0;
      host_busy <= 1'b0;
      usb_int   <= 1'b0;
      hist      <= 16'h0000;
      for (int e = 0; e < 2; e++) begin
        cnt[e] <= 4'h0;
        rp[e]  <= 4'h0;
      end
    end else begin
      if (dev_we && dev_addr == DEV_MISC_ADDR) begin
        cmd_reg <= dev_wdata[4:0];
        hist    <= {hist[7:0], dev_wdata};
        if (!dev_wdata[MB_SETUP]) setup_reg <= 1'b0;
        if (dev_wdata[MB_CLR]) begin
          cnt[dev_wdata[MB_SEL]] <= 4'h0;
          rp[dev_wdata[MB_SEL]]  <= 4'h0;
        end
      end
      if (dev_we && dev_addr[7:1] == DEV_EP0_ADDR[7:1] && dev_addr[0] == ep && cmd_reg[MB_TX] && ready) begin
        mem[ep][cnt[ep][2:0]] <= dev_wdata;
        cnt[ep]               <= cnt[ep] + 4'h1;
      end
      if (dev_re && dev_addr == DEV_MISC_ADDR) begin
        dev_rdata <= {zlen_reg, ready, setup_reg, cmd_reg};
      end else if (dev_re && dev_addr[0] == ep && !cmd_reg[MB_TX] && ready) begin
        dev_rdata <= mem[ep][rp[ep][2:0]];
        rp[ep]    <= rp[ep] + 4'h1;
        zlen_reg  <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Host side: packet arrival, pipe ownership and completion
  task automatic host_load(input logic e, input logic setup, input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) mem[e][i] = base + 8'(i);
    cnt[e]   = 4'(n);
    rp[e]    = 4'h0;
    zlen_reg = (n == 0);
    if (setup) setup_reg = 1'b1;
  endtask

  task automatic host_use(input logic b);
    host_busy = b;
  endtask

  task automatic host_done(input logic p);
    @(posedge sys_clk);
    usb_int            <= 1'b1;
    active_pipe_number <= p;
    host_busy          <= 1'b0;
    @(posedge sys_clk);
    usb_int <= 1'b0;
  endtask
endmodule

// *** uefap_ctrl_tb_top.sv ***
module uefap_ctrl_tb_top
  import uefap_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk;
  logic        srst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  dev_addr;
  logic [7:0]  dev_wdata;
  logic        dev_we;
  logic        dev_re;
  logic [7:0]  dev_rdata;
  logic        usb_int;
  logic        active_pipe_number;
  logic [31:0] rd;
  int          n_mismatch = 0;
  int          comparisons = 0;

  uefap_ctrl dut (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_we(dev_we),
    .dev_re(dev_re), .dev_rdata(dev_rdata), .usb_int(usb_int), .active_pipe_number(active_pipe_number));
  uefap_dev_model dev (.sys_clk(sys_clk), .srst(srst), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_we(dev_we), .dev_re(dev_re), .dev_rdata(dev_rdata), .usb_int(usb_int),
    .active_pipe_number(active_pipe_number));

  //////////////////////////////////////////////////////////////////////////////
  // Clock and Avalon master; requests held until waitrequest is seen low
  always #50 sys_clk = ~sys_clk;
  task automatic av_write(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic av_read(input logic [5:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] op, input logic sel, input logic [3:0] len, input logic keep);
    return {22'h0, keep, len, sel, op, 1'b1};
  endfunction
  // Busy polling has no bound of its own; the watchdog covers a hang
  task automatic run_op(input logic [31:0] c);
    av_write(AV_CTRL, c);
    do av_read(AV_STATUS, rd); while (rd[0] !== 1'b0);
  endtask
  task automatic end_of_test;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog, well above the thousand or so cycles the sequence needs
  initial begin
    #3000000;
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    sys_clk = 1'b0;
    srst = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    av_read(AV_STATUS, rd);
    chk(rd, 32'h0, "idle status");
    av_read(6'h10, rd);
    chk(rd, 32'h0, "unmapped read");
    // Three bytes into the interrupt fifo
    for (int i = 0; i < 3; i++) av_write(6'h20 + 6'(4 * i), 32'(8'ha1 + 8'(i)));
    run_op(ctl(OP_WRITE, 1'b1, 4'h3, 1'b0));
    chk(32'(dev.cnt[1]), 32'h3, "ep1 count");
    for (int i = 0; i < 3; i++) chk(32'(dev.mem[1][i]), 32'(8'ha1 + 8'(i)), "ep1 byte");
    chk(32'(dev.hist), 32'h0908, "ep1 write end");
    // Over-long length is clipped to a full fifo
    for (int i = 0; i < 8; i++) av_write(6'h20 + 6'(4 * i), 32'h10 + 32'(i));
    run_op(ctl(OP_WRITE, 1'b0, 4'h9, 1'b0));
    chk(32'(dev.cnt[0]), 32'h8, "ep0 full");
    chk(32'(dev.mem[0][7]), 32'h17, "ep0 last byte");
    run_op(ctl(OP_CLEAR, 1'b0, 4'h0, 1'b0));
    chk(32'(dev.cnt[0]), 32'h0, "ep0 cleared");
    run_op(ctl(OP_WRITE, 1'b0, 4'h0, 1'b0));
    chk(32'(dev.hist), 32'h0100, "empty packet end");
    // Setup packet read, setup flag kept; the end words carry the keep bit too
    dev.host_load(1'b0, 1'b1, 4, 8'h30);
    run_op(ctl(OP_READ, 1'b0, 4'h0, 1'b1));
    av_read(AV_STATUS, rd);
    chk(rd & 32'h00ff_0f1e, 32'h0021_040a, "read status");
    for (int i = 0; i < 4; i++) begin
      av_read(6'h20 + 6'(4 * i), rd);
      chk(rd, 32'h30 + 32'(i), "rx byte");
    end
    chk(32'(dev.hist), 32'h2322, "read end");
    // Host owns the pipe while an empty packet waits
    dev.host_use(1'b1);
    dev.host_load(1'b0, 1'b0, 0, 8'h00);
    run_op(ctl(OP_PRB_R, 1'b0, 4'h0, 1'b0));
    av_read(AV_STATUS, rd);
    chk(rd & 32'h00ff_0014, 32'h0081_0010, "blocked probe");
    dev.host_done(1'b0);
    av_read(AV_PIPE, rd);
    chk(rd, 32'h1, "pipe 0 event");
    av_write(AV_CTRL, 32'h400);
    av_read(AV_PIPE, rd);
    chk(rd, 32'h0, "pipe ack");
    dev.host_done(1'b1);
    av_read(AV_PIPE, rd);
    chk(rd, 32'h3, "pipe 1 event");
    // Loading a two-byte setup packet wipes the zero-length flag before any fifo read can
    dev.host_load(1'b0, 1'b1, 2, 8'h50);
    run_op(ctl(OP_PRB_R, 1'b0, 4'h0, 1'b1));
    av_read(AV_STATUS, rd);
    chk(rd & 32'h00ff_0014, 32'h0061_0004, "setup probe");
    run_op(ctl(OP_READ, 1'b0, 4'h0, 1'b1));
    av_read(AV_STATUS, rd);
    chk(rd & 32'h0000_0f18, 32'h0000_0208, "setup read");
    // Probe with data waiting, no transfer
    dev.host_load(1'b0, 1'b0, 1, 8'h77);
    run_op(ctl(OP_PRB_R, 1'b0, 4'h0, 1'b0));
    av_read(AV_STATUS, rd);
    chk(rd & 32'h00ff_0004, 32'h0041_0004, "probe ready");
    chk(32'(dev.hist), 32'h0100, "probe withdraw");
    chk(32'(dev.rp[0]), 32'h0, "probe moved no data");
    // Write probe on the interrupt fifo, which still holds three bytes
    run_op(ctl(OP_PRB_W, 1'b1, 4'h0, 1'b0));
    av_read(AV_STATUS, rd);
    chk(rd & 32'h00ff_0004, 32'h004b_0004, "write probe ready");
    chk(32'(dev.hist), 32'h0b0a, "write probe withdraw");
    av_read(AV_CTRL, rd);
    chk(rd, ctl(OP_PRB_W, 1'b1, 4'h0, 1'b0) & 32'h0000_03fe, "control readback");
    end_of_test;
  end
endmodule
